// *** exposure_trigger_pkg.sv ***
// Constants, field layout and helpers for the line exposure and trigger control block.
package exposure_trigger_pkg;

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets.
localparam logic [7:0] OFF_TRIG_CFG = 8'h00;
localparam logic [7:0] OFF_EXPO_CFG = 8'h04;
localparam logic [7:0] OFF_DURATION = 8'h08;
localparam logic [7:0] OFF_STATUS = 8'h0c;
localparam logic [7:0] OFF_DUR_RED = 8'h10;
localparam logic [7:0] OFF_DUR_GREEN = 8'h14;
localparam logic [7:0] OFF_DUR_BLUE = 8'h18;
localparam logic [7:0] OFF_LINE_PERIOD = 8'h1c;

// Field positions.
localparam int TRIG_KIND_LSB = 0;
localparam int TRIG_POL_LSB = 4;
localparam int EXPO_METHOD_LSB = 0;
localparam int EXPO_SHARE_BIT = 4;
localparam int EXPO_PICK_LSB = 8;
localparam int EXPO_PRIO_BIT = 12;
localparam int EXPO_LOCK_BIT = 16;
localparam int ST_ACQ_BIT = 0;
localparam int ST_EXPOSE_LSB = 4;
localparam int ST_BUSY_BIT = 8;
localparam int ST_TRIG_BIT = 9;
localparam int ST_OVERRUN_LSB = 16;

////////////////////////////////////////////////////////////////////////////////
// Field codes and reset values.
localparam logic [1:0] KIND_ACQ_START = 2'h0;
localparam logic [1:0] KIND_ACQ_END = 2'h1;
localparam logic [1:0] KIND_PER_LINE = 2'h2;
localparam logic [2:0] POL_RISE = 3'h1;
localparam logic [2:0] POL_FALL = 3'h2;
localparam logic [2:0] POL_HIGH = 3'h3;
localparam logic [2:0] POL_LOW = 3'h4;
localparam logic [1:0] METHOD_OFF = 2'h0;
localparam logic [1:0] METHOD_PRESET = 2'h1;
localparam logic [1:0] METHOD_PULSE = 2'h2;
localparam logic [1:0] PICK_COMMON = 2'h0;
localparam logic [1:0] PICK_RED = 2'h1;
localparam logic [1:0] PICK_GREEN = 2'h2;
localparam logic [1:0] PICK_BLUE = 2'h3;
localparam logic [1:0] KIND_RESET = KIND_ACQ_START;
localparam logic [2:0] POL_RESET = POL_RISE;
localparam logic [1:0] METHOD_RESET = METHOD_PRESET;
localparam logic SHARE_RESET = 1'h0;
localparam logic [1:0] PICK_RESET = PICK_COMMON;
localparam logic PRIO_RESET = 1'h0;
localparam logic LOCK_RESET = 1'h0;

////////////////////////////////////////////////////////////////////////////////
// Durations are held in hundredths of a microsecond.
localparam int DUR_WIDTH = 21;
localparam int PROD_WIDTH = 2 * DUR_WIDTH;
localparam logic [20:0] DUR_MIN_CUS = 21'h00012c;
localparam logic [20:0] DUR_MAX_CUS = 21'h171d9b;
localparam logic [20:0] DUR_OFFSET_CUS = 21'h000055;
localparam int CLK_PERIOD_NS = 100;
localparam int NS_PER_CUS = 10;
localparam logic [21:0] CUS_PER_CYCLE = 22'(CLK_PERIOD_NS / NS_PER_CUS);
localparam int CLK_HZ = 10000000;
localparam int LINE_RATE_HZ = 66;
localparam logic [31:0] LINE_PERIOD_CYCLES = 32'(CLK_HZ / LINE_RATE_HZ);

function automatic logic [DUR_WIDTH-1:0] clampDur(input logic [PROD_WIDTH-1:0] v);
	if (v < {21'h0, DUR_MIN_CUS}) begin
		return DUR_MIN_CUS;
	end
	if (v > {21'h0, DUR_MAX_CUS}) begin
		return DUR_MAX_CUS;
	end
	return v[DUR_WIDTH-1:0];
endfunction

endpackage

// *** ratio_rescale.sv ***
// Sequential rescaler: result = value * newRef / oldRef, clamped to the duration range.
module ratio_rescale
	import exposure_trigger_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Request
	input wire logic start,
	input wire logic [DUR_WIDTH-1:0] value,
	input wire logic [DUR_WIDTH-1:0] newRef,
	input wire logic [DUR_WIDTH-1:0] oldRef,
	// Answer
	output logic busy,
	output logic done,
	output logic [DUR_WIDTH-1:0] result
);

typedef enum logic [1:0] {IDLE, DIVIDE, CLAMP} rescale_state_type;

rescale_state_type state_r;
logic [5:0] step_r;
logic [PROD_WIDTH-1:0] dvd_r;
logic [DUR_WIDTH:0] rem_r;
logic [DUR_WIDTH-1:0] div_r;
logic done_r;
logic [DUR_WIDTH-1:0] result_r;
logic [DUR_WIDTH:0] remShift;

// A restoring divider keeps the area small; one quotient bit per cycle is ample here.
assign remShift = {rem_r[DUR_WIDTH-1:0], dvd_r[PROD_WIDTH-1]};

always_ff @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		state_r <= IDLE;
		step_r <= 6'h00;
		dvd_r <= '0;
		rem_r <= '0;
		div_r <= '0;
		done_r <= 1'b0;
		result_r <= '0;
	end else begin
		done_r <= 1'b0;
		unique case (state_r)
			IDLE: begin
				if (start) begin
					dvd_r <= {21'h0, value} * {21'h0, newRef};
					rem_r <= '0;
					div_r <= oldRef;
					step_r <= 6'h00;
					state_r <= DIVIDE;
				end
			end
			DIVIDE: begin
				if (remShift >= {1'b0, div_r}) begin
					rem_r <= remShift - {1'b0, div_r};
					dvd_r <= {dvd_r[PROD_WIDTH-2:0], 1'b1};
				end else begin
					rem_r <= remShift;
					dvd_r <= {dvd_r[PROD_WIDTH-2:0], 1'b0};
				end
				step_r <= step_r + 6'h01;
				if (step_r == 6'(PROD_WIDTH - 1)) begin
					state_r <= CLAMP;
				end
			end
			CLAMP: begin
				result_r <= clampDur(dvd_r);
				done_r <= 1'b1;
				state_r <= IDLE;
			end
		endcase
	end
end

assign busy = (state_r != IDLE);
assign done = done_r;
assign result = result_r;

endmodule

// *** line_exposure_trigger_control.sv ***
// Trigger recognition, exposure timing and APB registers for a three-sensor line camera.
//
// The implementer's own choices: the address map and the APB interface to the registers.
module line_exposure_trigger_control
	import exposure_trigger_pkg::*;
#(
	parameter logic [31:0] LinePeriodDefault = LINE_PERIOD_CYCLES,
	parameter logic [DUR_WIDTH-1:0] DurReset = DUR_MAX_CUS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Trigger pin
	input wire logic triggerIn,
	// Sensor exposure and line strobe
	output logic exposeRed,
	output logic exposeGreen,
	output logic exposeBlue,
	output logic lineStrobe
);

default clocking cb @(posedge clk);
endclocking
default disable iff (!reset_n);

////////////////////////////////////////////////////////////////////////////////
// Configuration state.
logic [1:0] kind_r;
logic [2:0] polarity_r;
logic [1:0] method_r;
logic sharing_r;
logic [1:0] pick_r;
logic favourLine_r;
logic ratioLock_r;
logic [31:0] linePeriod_r;
logic [DUR_WIDTH-1:0] dur_r [4];

// APB state.
logic pready_r;
logic pslverr_r;
logic [31:0] prdata_r;
logic accessNew;
logic stall;
logic wrCommit;
logic wrDur;
logic [1:0] tgt;
logic [DUR_WIDTH-1:0] wrVal;
logic addrErr;
logic [31:0] readVal;

// Trigger and line state.
logic trigMeta_r;
logic trigSync_r;
logic prevSync_r;
logic riseActive;
logic activeLvl;
logic trigEvent;
logic acquiring_r;
logic [31:0] lineCnt_r;
logic lineEvent;
logic lineStrobe_r;
logic pulseMode;
logic [2:0] expose_r;
logic [15:0] overrun_r;

// Ratio rescale.
logic rescaleStart;
logic busyR;
logic busyB;
logic doneR;
logic doneB;
logic [DUR_WIDTH-1:0] resR;
logic [DUR_WIDTH-1:0] resB;

function automatic logic comboLegal(input logic [1:0] k, input logic [2:0] p, input logic [1:0] m);
	logic isLevel;
	isLevel = (p == POL_HIGH) || (p == POL_LOW);
	if (p < POL_RISE || p > POL_LOW || m > METHOD_PULSE || k > KIND_PER_LINE) begin
		return 1'b0;
	end
	if (k == KIND_PER_LINE) begin
		return (m == METHOD_PULSE) ? isLevel : !isLevel;
	end
	return 1'b1;
endfunction

////////////////////////////////////////////////////////////////////////////////
// APB slave: pready rises one cycle into the access phase and the write lands on the next edge, which ends the transfer.
// A duration write is held off while a ratio rescale is in flight.
assign stall = pwrite && (paddr == OFF_DURATION) && (busyR || busyB);
assign accessNew = psel && penable && !pready_r && !stall;
assign wrCommit = psel && penable && pready_r && pwrite && !pslverr_r;
assign tgt = (method_r == METHOD_PRESET) ? pick_r : PICK_COMMON;
assign wrVal = clampDur({10'h000, pwdata});
assign wrDur = wrCommit && (paddr == OFF_DURATION);

always_comb begin
	addrErr = 1'b0;
	readVal = 32'h0000_0000;
	unique case (paddr)
		OFF_TRIG_CFG: begin
			readVal[TRIG_KIND_LSB +: 2] = kind_r;
			readVal[TRIG_POL_LSB +: 3] = polarity_r;
			addrErr = pwrite && !comboLegal(pwdata[TRIG_KIND_LSB +: 2],
				pwdata[TRIG_POL_LSB +: 3], method_r);
		end
		OFF_EXPO_CFG: begin
			readVal[EXPO_METHOD_LSB +: 2] = method_r;
			readVal[EXPO_SHARE_BIT] = sharing_r;
			readVal[EXPO_PICK_LSB +: 2] = pick_r;
			readVal[EXPO_PRIO_BIT] = favourLine_r;
			readVal[EXPO_LOCK_BIT] = ratioLock_r;
			addrErr = pwrite && !comboLegal(kind_r, polarity_r, pwdata[EXPO_METHOD_LSB +: 2]);
		end
		OFF_DURATION: readVal[DUR_WIDTH-1:0] = dur_r[tgt];
		OFF_STATUS: begin
			readVal[ST_ACQ_BIT] = acquiring_r;
			readVal[ST_EXPOSE_LSB +: 3] = expose_r;
			readVal[ST_BUSY_BIT] = busyR || busyB;
			readVal[ST_TRIG_BIT] = trigSync_r;
			readVal[ST_OVERRUN_LSB +: 16] = overrun_r;
			addrErr = pwrite;
		end
		OFF_DUR_RED: begin
			readVal[DUR_WIDTH-1:0] = dur_r[PICK_RED];
			addrErr = pwrite;
		end
		OFF_DUR_GREEN: begin
			readVal[DUR_WIDTH-1:0] = dur_r[PICK_GREEN];
			addrErr = pwrite;
		end
		OFF_DUR_BLUE: begin
			readVal[DUR_WIDTH-1:0] = dur_r[PICK_BLUE];
			addrErr = pwrite;
		end
		OFF_LINE_PERIOD: readVal = linePeriod_r;
		default: addrErr = 1'b1;
	endcase
end

always_ff @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		pready_r <= 1'b0;
		pslverr_r <= 1'b0;
		prdata_r <= 32'h0000_0000;
	end else begin
		pready_r <= accessNew;
		pslverr_r <= accessNew && addrErr;
		if (accessNew) begin
			prdata_r <= readVal;
		end
	end
end

assign pready = pready_r;
assign pslverr = pslverr_r;
assign prdata = prdata_r;

////////////////////////////////////////////////////////////////////////////////
// Configuration registers; illegal combinations were already refused with pslverr.
always_ff @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		kind_r <= KIND_RESET;
		polarity_r <= POL_RESET;
		method_r <= METHOD_RESET;
		sharing_r <= SHARE_RESET;
		pick_r <= PICK_RESET;
		favourLine_r <= PRIO_RESET;
		ratioLock_r <= LOCK_RESET;
		linePeriod_r <= LinePeriodDefault;
	end else if (wrCommit) begin
		if (paddr == OFF_TRIG_CFG) begin
			kind_r <= pwdata[TRIG_KIND_LSB +: 2];
			polarity_r <= pwdata[TRIG_POL_LSB +: 3];
		end
		if (paddr == OFF_EXPO_CFG) begin
			method_r <= pwdata[EXPO_METHOD_LSB +: 2];
			sharing_r <= pwdata[EXPO_SHARE_BIT];
			pick_r <= pwdata[EXPO_PICK_LSB +: 2];
			favourLine_r <= pwdata[EXPO_PRIO_BIT];
			ratioLock_r <= pwdata[EXPO_LOCK_BIT];
		end
		if (paddr == OFF_LINE_PERIOD) begin
			linePeriod_r <= (pwdata == 32'h0000_0000) ? 32'h0000_0001 : pwdata;
		end
	end
end

// Index 0 holds the common duration, 1 to 3 the red, green and blue ones.
always_ff @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		for (int i = 0; i < 4; i++) begin
			dur_r[i] <= DurReset;
		end
	end else begin
		if (wrDur) begin
			dur_r[tgt] <= wrVal;
		end
		if (doneR) begin
			dur_r[PICK_RED] <= resR;
			dur_r[PICK_BLUE] <= resB;
		end
	end
end

assign rescaleStart = wrDur && (tgt == PICK_GREEN) && ratioLock_r;

ratio_rescale rescaleRed (
	.clk(clk),
	.reset_n(reset_n),
	.start(rescaleStart),
	.value(dur_r[PICK_RED]),
	.newRef(wrVal),
	.oldRef(dur_r[PICK_GREEN]),
	.busy(busyR),
	.done(doneR),
	.result(resR)
);

ratio_rescale rescaleBlue (
	.clk(clk),
	.reset_n(reset_n),
	.start(rescaleStart),
	.value(dur_r[PICK_BLUE]),
	.newRef(wrVal),
	.oldRef(dur_r[PICK_GREEN]),
	.busy(busyB),
	.done(doneB),
	.result(resB)
);

////////////////////////////////////////////////////////////////////////////////
// Trigger recognition: the pin is synchronised, then turned into an active level.
// Level codes give an event on entry into the level, so acquisition kinds still see one.
always_ff @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		trigMeta_r <= 1'b0;
		trigSync_r <= 1'b0;
		prevSync_r <= 1'b0;
	end else begin
		trigMeta_r <= triggerIn;
		trigSync_r <= trigMeta_r;
		prevSync_r <= trigSync_r;
	end
end

assign riseActive = (polarity_r == POL_RISE) || (polarity_r == POL_HIGH);
assign activeLvl = riseActive ? trigSync_r : !trigSync_r;
// Edges are taken on the synchronised pin, so rewriting the polarity never fakes a trigger.
assign trigEvent = riseActive ? (trigSync_r && !prevSync_r) :
	(!trigSync_r && prevSync_r);
assign pulseMode = (method_r == METHOD_PULSE) && (kind_r == KIND_PER_LINE);

always_ff @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		acquiring_r <= 1'b0;
	end else if (trigEvent && kind_r == KIND_ACQ_START) begin
		acquiring_r <= 1'b1;
	end else if (trigEvent && kind_r == KIND_ACQ_END) begin
		acquiring_r <= 1'b0;
	end
end

// Outside per-line triggering, lines are paced by the internal line period.
always_ff @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		lineCnt_r <= 32'h0000_0000;
	end else if (!acquiring_r || kind_r == KIND_PER_LINE || lineCnt_r >= linePeriod_r - 32'h1) begin
		lineCnt_r <= 32'h0000_0000;
	end else begin
		lineCnt_r <= lineCnt_r + 32'h1;
	end
end

assign lineEvent = (kind_r == KIND_PER_LINE) ? trigEvent :
	(acquiring_r && lineCnt_r >= linePeriod_r - 32'h1);

always_ff @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		lineStrobe_r <= 1'b0;
	end else begin
		lineStrobe_r <= lineEvent;
	end
end

always_ff @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		overrun_r <= 16'h0000;
	end else if (lineEvent && method_r != METHOD_OFF && !pulseMode && |expose_r) begin
		overrun_r <= overrun_r + 16'h0001;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Per-channel exposure timers; counts run in hundredths of a microsecond.
logic [DUR_WIDTH-1:0] cnt_r [3];
logic [DUR_WIDTH-1:0] effDur [3];
logic [DUR_WIDTH-1:0] target [3];

generate
	for (genvar c = 0; c < 3; c++) begin : gChan
		assign effDur[c] = (method_r == METHOD_PRESET && sharing_r) ? dur_r[c + 1] : dur_r[0];
		assign target[c] = effDur[c] - DUR_OFFSET_CUS;

		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				cnt_r[c] <= '0;
				expose_r[c] <= 1'b0;
			end else if (pulseMode) begin
				expose_r[c] <= activeLvl;
				cnt_r[c] <= '0;
			end else if (method_r == METHOD_OFF) begin
				if (lineEvent) begin
					expose_r[c] <= 1'b1;
				end else if (kind_r != KIND_PER_LINE && !acquiring_r) begin
					expose_r[c] <= 1'b0;
				end
			end else if (lineEvent && (!expose_r[c] || favourLine_r)) begin
				expose_r[c] <= 1'b1;
				cnt_r[c] <= '0;
			end else if (expose_r[c]) begin
				if ({1'b0, cnt_r[c]} + CUS_PER_CYCLE >= {1'b0, target[c]}) begin
					expose_r[c] <= 1'b0;
				end else begin
					cnt_r[c] <= cnt_r[c] + CUS_PER_CYCLE[DUR_WIDTH-1:0];
				end
			end
		end
	end
endgenerate

assign exposeRed = expose_r[0];
assign exposeGreen = expose_r[1];
assign exposeBlue = expose_r[2];
assign lineStrobe = lineStrobe_r;

////////////////////////////////////////////////////////////////////////////////
// Checks.
int lenCnt_r;

always_ff @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		lenCnt_r <= 0;
	end else if (expose_r[1] && !$past(expose_r[1])) begin
		lenCnt_r <= 1;
	end else if (expose_r[1]) begin
		lenCnt_r <= lenCnt_r + 1;
	end
end

sequence presetStart_s;
	lineEvent && method_r == METHOD_PRESET && expose_r[1];
endsequence

sequence greenWrite_s;
	rescaleStart;
endsequence

rise_edge_seen_a: assert property (polarity_r == POL_RISE && trigSync_r && !$past(trigSync_r) && $stable(polarity_r) |-> trigEvent) else $error("rising trigger missed");
edge_only_a: assert property (kind_r == KIND_PER_LINE && method_r != METHOD_PULSE |-> polarity_r == POL_RISE || polarity_r == POL_FALL) else $error("level used with edge method");
level_only_a: assert property (kind_r == KIND_PER_LINE && method_r == METHOD_PULSE |-> polarity_r == POL_HIGH || polarity_r == POL_LOW) else $error("edge used with pulse method");
method_code_a: assert property (method_r != 2'h3) else $error("illegal exposure method");
shared_write_a: assert property (wrDur && method_r != METHOD_PRESET |=> $stable(dur_r[1]) && $stable(dur_r[2]) && $stable(dur_r[3]) && dur_r[0] == $past(wrVal)) else $error("pick used outside preset");
pick_write_a: assert property (wrDur && method_r == METHOD_PRESET && pick_r == PICK_BLUE |=> dur_r[3] == $past(wrVal) && $stable(dur_r[0])) else $error("blue write misdirected");
dur_range_a: assert property (dur_r[1] >= DUR_MIN_CUS && dur_r[1] <= DUR_MAX_CUS && dur_r[0] >= DUR_MIN_CUS && dur_r[0] <= DUR_MAX_CUS) else $error("duration out of range");
expose_len_a: assert property ($fell(expose_r[1]) && method_r == METHOD_PRESET && !favourLine_r && $stable(target[1]) |-> lenCnt_r * 10 >= int'(target[1]) && (lenCnt_r - 1) * 10 < int'(target[1])) else $error("exposure length wrong");
line_favour_a: assert property (presetStart_s ##0 favourLine_r |=> expose_r[1] && cnt_r[1] == '0) else $error("line pace did not restart");
duration_favour_a: assert property (presetStart_s ##0 !favourLine_r && !$fell(expose_r[1]) ##0 cnt_r[1] != '0 |=> cnt_r[1] != '0 || !expose_r[1]) else $error("exposure cut short");
ratio_done_a: assert property (greenWrite_s |-> ##[40:50] doneR && doneB) else $error("rescale did not finish");
acq_start_a: assert property (trigEvent && kind_r == KIND_ACQ_START |=> acquiring_r) else $error("acquisition did not start");
pulse_follow_a: assert property (pulseMode && $stable(pulseMode) |-> expose_r[1] == $past(activeLvl)) else $error("pulse exposure mismatch");

endmodule

// *** trigger_source.sv ***
// Far-side trigger source model driving the trigger pin.
module trigger_source (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Request from the bench
	input wire logic fire,
	input wire logic [7:0] width,
	// Trigger pin
	output logic triggerIn
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] holdCnt_r;
	////////////////////////////////////////////////////////////////////////////////
	// One pulse of width cycles per request; a request during a pulse restarts its width instead of adding a second pulse.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			holdCnt_r <= 8'h00;
		end else if (fire) begin
			holdCnt_r <= width;
		end else if (holdCnt_r != 8'h00) begin
			holdCnt_r <= holdCnt_r - 8'h01;
		end
	end
	assign triggerIn = (holdCnt_r != 8'h00);
endmodule

// *** tb_top.sv ***
// Self-checking bench for the line exposure and trigger control block.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import exposure_trigger_pkg::*;
	logic clk, reset_n, psel, penable, pwrite, pready, pslverr, fire, clr, err;
	logic exposeRed, exposeGreen, exposeBlue, lineStrobe, triggerIn;
	logic [7:0] paddr, width;
	logic [31:0] pwdata, prdata, rd;
	logic [20:0] dv;
	logic [15:0] ov;
	logic [15:0] cnt [4];
	logic [3:0] mon;
	int error_cnt, checked, seed, i;

	line_exposure_trigger_control #(.LinePeriodDefault(32'h000000c8), .DurReset(21'h000190)) i_dut (
		.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.triggerIn(triggerIn), .exposeRed(exposeRed), .exposeGreen(exposeGreen),
		.exposeBlue(exposeBlue), .lineStrobe(lineStrobe));
	trigger_source i_src (.clk(clk), .reset_n(reset_n), .fire(fire), .width(width),
		.triggerIn(triggerIn));

	////////////////////////////////////////////////////////////////////////////////
	assign mon = {lineStrobe, exposeBlue, exposeGreen, exposeRed};
	always @(posedge clk) begin
		for (int k = 0; k < 4; k++) begin
			cnt[k] <= clr ? 16'h0000 : cnt[k] + 16'(mon[k]);
		end
	end

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	function automatic logic [15:0] expCyc(input logic [20:0] d);
		return 16'((d - DUR_OFFSET_CUS + 21'h000009) / 21'h00000a);
	endfunction

	function automatic logic [20:0] clampE(input logic [20:0] v);
		return (v < DUR_MIN_CUS) ? DUR_MIN_CUS : ((v > DUR_MAX_CUS) ? DUR_MAX_CUS : v);
	endfunction

	task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chkFlag(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// The trailing edge keeps a release and the next setup out of one time step.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 200);
		rd = prdata;
		err = pslverr;
		if (n >= 200) error_cnt++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic setup(input logic [31:0] ex, input logic [31:0] tc);
		apb(1'b1, OFF_TRIG_CFG, 32'h00000010);
		apb(1'b1, OFF_EXPO_CFG, ex);
		apb(1'b1, OFF_TRIG_CFG, tc);
		chkFlag(err, 1'b0);
	endtask

	task automatic pulse(input logic [7:0] w, input int gap, input logic c);
		fire <= 1'b1;
		width <= w;
		clr <= c;
		@(posedge clk);
		fire <= 1'b0;
		clr <= 1'b0;
		repeat (gap) @(posedge clk);
	endtask

	task automatic final_report;
		$display("counts: checked %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		final_report;
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'h0a0667c7;
		{psel, penable, pwrite, fire, err} = 5'h00;
		{paddr, width, pwdata} = 48'h0;
		clr = 1'b1;
		reset_n = 1'b0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		apb(1'b0, OFF_TRIG_CFG, 32'h0);
		chkReg(rd, 32'h00000010);
		apb(1'b0, OFF_EXPO_CFG, 32'h0);
		chkReg(rd, 32'h00000001);
		apb(1'b0, OFF_DURATION, 32'h0);
		chkReg(rd, 32'h00000190);
		apb(1'b0, 8'h20, 32'h0);
		chkFlag(err, 1'b1);
		$display("test reset_values done");
		for (i = 7; i >= 0; i--) begin
			apb(1'b1, OFF_TRIG_CFG, {25'h0, i[2:0], 4'h2});
			chkFlag(err, 1'(i != 1 && i != 2));
		end
		apb(1'b1, OFF_EXPO_CFG, 32'h00000002);
		chkFlag(err, 1'b1);
		apb(1'b1, OFF_EXPO_CFG, 32'h00000003);
		chkFlag(err, 1'b1);
		$display("test legality done");
		setup(32'h00000302, 32'h00000032);
		pulse(8'h14, 40, 1'b1);
		chkReg({16'h0, cnt[1]}, 32'h00000014);
		chkReg({16'h0, cnt[3]}, 32'h00000001);
		apb(1'b1, OFF_TRIG_CFG, 32'h00000012);
		chkFlag(err, 1'b1);
		apb(1'b1, OFF_DURATION, 32'h00000258);
		apb(1'b0, OFF_DUR_BLUE, 32'h0);
		chkReg(rd, 32'h00000190);
		apb(1'b0, OFF_DURATION, 32'h0);
		chkReg(rd, 32'h00000258);
		$display("test pulse_width done");
		setup(32'h00000001, 32'h00000012);
		for (i = 0; i < 12; i++) begin
			dv = (i < 2) ? (i == 1 ? 21'h171d9c : 21'h00012b) : 21'($random(seed));
			apb(1'b1, OFF_DURATION, {11'h0, dv});
			apb(1'b0, OFF_DURATION, 32'h0);
			chkReg(rd, {11'h0, clampE(dv)});
		end
		apb(1'b1, OFF_DURATION, 32'h00000190);
		$display("test duration_range done");
		apb(1'b1, OFF_EXPO_CFG, 32'h00000111);
		apb(1'b1, OFF_DURATION, 32'h000001f4);
		apb(1'b1, OFF_EXPO_CFG, 32'h00000311);
		apb(1'b1, OFF_DURATION, 32'h000003e8);
		pulse(8'h02, 120, 1'b1);
		chkReg({16'h0, cnt[0]}, {16'h0, expCyc(21'h0001f4)});
		chkReg({16'h0, cnt[1]}, {16'h0, expCyc(21'h000190)});
		chkReg({16'h0, cnt[2]}, {16'h0, expCyc(21'h0003e8)});
		apb(1'b0, OFF_DUR_RED, 32'h0);
		chkReg(rd, 32'h000001f4);
		$display("test channels done");
		apb(1'b1, OFF_EXPO_CFG, 32'h00010211);
		apb(1'b1, OFF_DURATION, 32'h00000320);
		i = 0;
		do begin
			apb(1'b0, OFF_STATUS, 32'h0);
			i++;
		end while (rd[ST_BUSY_BIT] !== 1'b0 && i < 100);
		apb(1'b0, OFF_DUR_RED, 32'h0);
		chkReg(rd, 32'h000003e8);
		apb(1'b0, OFF_DUR_BLUE, 32'h0);
		chkReg(rd, 32'h000007d0);
		$display("test ratio_lock done");
		for (i = 0; i < 2; i++) begin
			apb(1'b1, OFF_EXPO_CFG, 32'h00000011 | (i << EXPO_PRIO_BIT));
			apb(1'b0, OFF_STATUS, 32'h0);
			ov = rd[31:16];
			pulse(8'h02, 19, 1'b1);
			pulse(8'h02, 250, 1'b0);
			chkReg({16'h0, cnt[1]}, {16'h0, expCyc(21'h000320) + (i ? 16'h0014 : 16'h0)});
			apb(1'b0, OFF_STATUS, 32'h0);
			chkReg({16'h0, rd[31:16]}, {16'h0, ov + 16'h0001});
		end
		$display("test priority done");
		apb(1'b1, OFF_EXPO_CFG, 32'h00000000);
		apb(1'b1, OFF_TRIG_CFG, 32'h00000020);
		chkFlag(err, 1'b0);
		pulse(8'h02, 450, 1'b1);
		chkReg({16'h0, cnt[3]}, 32'h00000002);
		chkReg({16'h0, cnt[1]}, 32'h000000f4);
		apb(1'b0, OFF_STATUS, 32'h0);
		chkFlag(rd[ST_ACQ_BIT], 1'b1);
		apb(1'b1, OFF_TRIG_CFG, 32'h00000021);
		pulse(8'h02, 10, 1'b0);
		apb(1'b0, OFF_STATUS, 32'h0);
		chkFlag(rd[ST_ACQ_BIT], 1'b0);
		chkFlag(rd[ST_EXPOSE_LSB + 1], 1'b0);
		$display("test acquisition done");
		final_report;
	end
endmodule
